// >>> core/i2tm_cnt_if.sv
// carrier between the supervisor and its time-out counter
`include "i2tm_params.svh"
interface i2tm_cnt_if;
  import i2tm_pkg::*;

  logic run;
  logic clear;
  logic sub_rise;
  logic [`I2TM_SEL_W-1:0] sel;
  logic expire;

  modport ctl (output run, output clear, output sub_rise, output sel, input expire);
  modport cnt (input run, input clear, input sub_rise, input sel, output expire);
endinterface : i2tm_cnt_if

// >>> core/i2tm_counter.sv
// time-out counter: sub clock divided by 32, compared with the period select
`include "i2tm_params.svh"
module i2tm_counter
  import i2tm_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  i2tm_cnt_if.cnt bus // control from the supervisor
);

  i2tm_cnt_s cnt_reg;
  i2tm_cnt_s cnt_next;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    cnt_next.expire = 1'b0;
    if (!bus.run || bus.clear) begin
      // held at zero while idle or disabled; scl fall restarts the period
      cnt_next.pre = '0;
      cnt_next.cnt = '0;
    end else if (bus.sub_rise) begin
      if (cnt_reg.pre == `I2TM_PRE_LAST) begin
        cnt_next.pre = '0;
        // (sel + 1) ticks of sub_clock / 32 make one period
        if (cnt_reg.cnt == bus.sel) begin
          cnt_next.expire = 1'b1;
          cnt_next.cnt = '0;
        end else begin
          cnt_next.cnt = cnt_reg.cnt + 6'h01;
        end
      end else begin
        cnt_next.pre = cnt_reg.pre + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign bus.expire = cnt_reg.expire;

endmodule : i2tm_counter

// >>> core/i2tm_params.svh
// offsets, field positions, reset values and counts of the i2c time-out supervisor
`ifndef I2TM_PARAMS_SVH
`define I2TM_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define I2TM_ADDR_W 8
`define I2TM_ADDR_CTRL 8'h00
`define I2TM_ADDR_INT_STAT 8'h04
`define I2TM_ADDR_INT_CLR 8'h08
`define I2TM_ADDR_INT_EN 8'h0C
`define I2TM_ADDR_SC2 8'h10

// ----------------------------------------------------------------------
// i2c_timeout_control fields
// ----------------------------------------------------------------------
`define I2TM_CTRL_EN_BIT 7
`define I2TM_CTRL_FLAG_BIT 6
`define I2TM_CTRL_SEL_MSB 5
`define I2TM_CTRL_SEL_LSB 0
`define I2TM_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// serial_control_second stand-in
// ----------------------------------------------------------------------
`define I2TM_SC2_AMF_BIT 0
`define I2TM_SC2_RESET 8'h00

// ----------------------------------------------------------------------
// interrupt status / clear / enable layout
// ----------------------------------------------------------------------
`define I2TM_INT_W 2
`define I2TM_INT_TO_BIT 0
`define I2TM_INT_AM_BIT 1
`define I2TM_INT_RESET 2'h0

// ----------------------------------------------------------------------
// timing: sub clock divided by 32, then 1 to 64 of those ticks
// ----------------------------------------------------------------------
`define I2TM_SUB_DIV 32
`define I2TM_PRE_W 5
`define I2TM_PRE_LAST 5'h1F
`define I2TM_SEL_W 6
`define I2TM_PERIODS 64

// ----------------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------------
`define I2TM_RESP_OKAY 2'h0
`define I2TM_RESP_SLVERR 2'h2

`endif

// >>> core/i2tm_pkg.sv
// types shared by the i2c time-out supervisor modules
`include "i2tm_params.svh"

package i2tm_pkg;

  // supervision phase of the bus
  typedef enum logic [1:0] {
    I2TM_IDLE,
    I2TM_ARMED,
    I2TM_RUNNING
  } i2tm_sup_e;

  // state of the time-out counter
  typedef struct packed {
    logic [`I2TM_PRE_W-1:0] pre;
    logic [`I2TM_SEL_W-1:0] cnt;
    logic expire;
  } i2tm_cnt_s;

  // state of the top module
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] sc2;
    logic [`I2TM_INT_W-1:0] ist;
    logic [`I2TM_INT_W-1:0] ien;
    i2tm_sup_e sup;
    logic eng_rst;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic sub_m;
    logic sub_s;
    logic sub_d;
  } i2tm_top_s;

endpackage : i2tm_pkg

// >>> core/i2tm_supervisor.sv
// i2c slave bus time-out supervisor with axi4-lite registers
// Notes on behaviour
// - counting starts after a start condition followed by own address match.
// - every scl falling edge clears the running counter to zero.
// - time-out when time since last scl fall exceeds selected period.
// - a stop condition halts the supervision.
// - on overflow counter stops, enable bit 7 cleared, flag bit 6 set.
// - time-out raises the same interrupt as other i2c slave events.
// - time-out resets engine and second control register; others untouched.
// - the flag stays set until software writes zero; never self-cleared.
// - six-bit select gives period (value + 1) times 32 sub clocks.
// - selectable periods range about 1 ms up to 64 ms.
`include "i2tm_params.svh"
module i2tm_supervisor
  import i2tm_pkg::*;
(
  input wire logic aclk, // system clock, 10 mhz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [`I2TM_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [`I2TM_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic scl_in, // scl pin level
  input wire logic sda_in, // sda pin level
  input wire logic sub_clock, // low speed sub clock pin
  input wire logic addr_match, // pulse from slave engine: own address seen
  output logic engine_reset, // pulse: reset the i2c slave state machine
  output logic [7:0] serial_control_second, // second control register to engine
  output logic irq // level interrupt
);

  i2tm_top_s st_reg;
  i2tm_top_s st_next;

  i2tm_cnt_if cnt_bus ();

  // ----------------------------------------------------------------------
  // time-out counter
  // ----------------------------------------------------------------------
  i2tm_counter u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(cnt_bus.cnt)
  );

  // ----------------------------------------------------------------------
  // edge and condition detection on synchronised pins
  // ----------------------------------------------------------------------
  logic scl_fall;
  logic sda_fall;
  logic sda_rise;
  logic bus_start;
  logic bus_stop;
  logic sub_rise;

  // only second-stage and later flops are looked at here
  assign scl_fall = st_reg.scl_d & ~st_reg.scl_s;
  assign sda_fall = st_reg.sda_d & ~st_reg.sda_s;
  assign sda_rise = ~st_reg.sda_d & st_reg.sda_s;
  assign bus_start = sda_fall & st_reg.scl_s & st_reg.scl_d;
  assign bus_stop = sda_rise & st_reg.scl_s & st_reg.scl_d;
  assign sub_rise = st_reg.sub_s & ~st_reg.sub_d;

  // ----------------------------------------------------------------------
  // counter control
  // ----------------------------------------------------------------------
  logic timeout_enable;
  logic timeout_flag;
  logic [`I2TM_SEL_W-1:0] timeout_period_select;

  assign timeout_enable = st_reg.ctrl[`I2TM_CTRL_EN_BIT];
  assign timeout_flag = st_reg.ctrl[`I2TM_CTRL_FLAG_BIT];
  assign timeout_period_select = st_reg.ctrl[`I2TM_CTRL_SEL_MSB:`I2TM_CTRL_SEL_LSB];

  // the counter only runs in the running phase with the enable set
  assign cnt_bus.run = (st_reg.sup == I2TM_RUNNING) & timeout_enable;
  assign cnt_bus.clear = scl_fall;
  assign cnt_bus.sub_rise = sub_rise;
  assign cnt_bus.sel = timeout_period_select;

  logic timeout_hit;

  // a late expire after the phase ended is ignored
  assign timeout_hit = cnt_bus.expire & (st_reg.sup == I2TM_RUNNING);

  // ----------------------------------------------------------------------
  // axi handshakes
  // ----------------------------------------------------------------------
  logic wr_go;
  logic rd_go;

  // address and data are taken together, one write outstanding at a time
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~st_reg.bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = s_axi_arvalid & ~st_reg.rvalid;
  assign s_axi_arready = rd_go;

  logic wr_ctrl;
  logic wr_clr;
  logic wr_en;
  logic wr_sc2;
  logic wr_hit;
  logic lane0;

  // narrow registers live in byte lane 0
  assign lane0 = s_axi_wstrb[0];
  assign wr_ctrl = wr_go & lane0 & (s_axi_awaddr == `I2TM_ADDR_CTRL);
  assign wr_clr = wr_go & lane0 & (s_axi_awaddr == `I2TM_ADDR_INT_CLR);
  assign wr_en = wr_go & lane0 & (s_axi_awaddr == `I2TM_ADDR_INT_EN);
  assign wr_sc2 = wr_go & lane0 & (s_axi_awaddr == `I2TM_ADDR_SC2);
  assign wr_hit = (s_axi_awaddr == `I2TM_ADDR_CTRL) | (s_axi_awaddr == `I2TM_ADDR_INT_STAT) |
                  (s_axi_awaddr == `I2TM_ADDR_INT_CLR) | (s_axi_awaddr == `I2TM_ADDR_INT_EN) |
                  (s_axi_awaddr == `I2TM_ADDR_SC2);

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  logic [31:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `I2TM_ADDR_CTRL: begin
        rd_word = {24'h000000, st_reg.ctrl};
      end
      `I2TM_ADDR_INT_STAT: begin
        rd_word = {30'h00000000, st_reg.ist};
      end
      `I2TM_ADDR_INT_CLR: begin
        rd_word = 32'h00000000; // write-only, reads zero
      end
      `I2TM_ADDR_INT_EN: begin
        rd_word = {30'h00000000, st_reg.ien};
      end
      `I2TM_ADDR_SC2: begin
        rd_word = {24'h000000, st_reg.sc2};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.eng_rst = 1'b0;

    // two-flop synchronisers, plus one delay stage for edges
    st_next.scl_m = scl_in;
    st_next.scl_s = st_reg.scl_m;
    st_next.scl_d = st_reg.scl_s;
    st_next.sda_m = sda_in;
    st_next.sda_s = st_reg.sda_m;
    st_next.sda_d = st_reg.sda_s;
    st_next.sub_m = sub_clock;
    st_next.sub_s = st_reg.sub_m;
    st_next.sub_d = st_reg.sub_s;

    // software writes to the control register
    if (wr_ctrl) begin
      st_next.ctrl[`I2TM_CTRL_EN_BIT] = s_axi_wdata[`I2TM_CTRL_EN_BIT];
      st_next.ctrl[`I2TM_CTRL_SEL_MSB:`I2TM_CTRL_SEL_LSB] =
        s_axi_wdata[`I2TM_CTRL_SEL_MSB:`I2TM_CTRL_SEL_LSB];
      // the flag can only be cleared; writing one leaves it alone
      if (!s_axi_wdata[`I2TM_CTRL_FLAG_BIT]) begin
        st_next.ctrl[`I2TM_CTRL_FLAG_BIT] = 1'b0;
      end
    end

    // software writes to the second control register; match flag clear-only
    if (wr_sc2) begin
      st_next.sc2[7:1] = s_axi_wdata[7:1];
      if (!s_axi_wdata[`I2TM_SC2_AMF_BIT]) begin
        st_next.sc2[`I2TM_SC2_AMF_BIT] = 1'b0;
      end
    end

    // interrupt enable and write-one-to-clear status
    if (wr_en) begin
      st_next.ien = s_axi_wdata[`I2TM_INT_W-1:0];
    end
    if (wr_clr) begin
      st_next.ist = st_reg.ist & ~s_axi_wdata[`I2TM_INT_W-1:0];
    end

    // supervision phase
    case (st_reg.sup)
      I2TM_IDLE: begin
        if (bus_start) begin
          st_next.sup = I2TM_ARMED;
        end
      end
      I2TM_ARMED: begin
        if (bus_stop) begin
          st_next.sup = I2TM_IDLE;
        end else if (addr_match) begin
          st_next.sup = I2TM_RUNNING;
        end
      end
      I2TM_RUNNING: begin
        if (bus_stop) begin
          st_next.sup = I2TM_IDLE;
        end
      end
      default: begin
        st_next.sup = I2TM_IDLE;
      end
    endcase

    // repeated start returns the running phase to armed for a fresh address
    if (bus_start && st_reg.sup == I2TM_RUNNING) begin
      st_next.sup = I2TM_ARMED;
    end

    // address match events set the match flag and its interrupt bit
    if (addr_match && st_reg.sup == I2TM_ARMED) begin
      st_next.sc2[`I2TM_SC2_AMF_BIT] = 1'b1;
      st_next.ist[`I2TM_INT_AM_BIT] = 1'b1;
    end

    // time-out: hardware wins over any software write in the same cycle
    if (timeout_hit) begin
      st_next.ctrl[`I2TM_CTRL_EN_BIT] = 1'b0;
      st_next.ctrl[`I2TM_CTRL_FLAG_BIT] = 1'b1;
      st_next.ist[`I2TM_INT_TO_BIT] = 1'b1;
      st_next.sc2 = `I2TM_SC2_RESET;
      st_next.eng_rst = 1'b1;
      st_next.sup = I2TM_IDLE;
    end

    // write response
    if (wr_go) begin
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_hit ? `I2TM_RESP_OKAY : `I2TM_RESP_SLVERR;
    end else if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // read response
    if (rd_go) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_word;
      st_next.rresp = rd_hit ? `I2TM_RESP_OKAY : `I2TM_RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg.ctrl <= `I2TM_CTRL_RESET;
      st_reg.sc2 <= `I2TM_SC2_RESET;
      st_reg.ist <= `I2TM_INT_RESET;
      st_reg.ien <= `I2TM_INT_RESET;
      st_reg.sup <= I2TM_IDLE;
      st_reg.eng_rst <= 1'b0;
      st_reg.bvalid <= 1'b0;
      st_reg.bresp <= `I2TM_RESP_OKAY;
      st_reg.rvalid <= 1'b0;
      st_reg.rdata <= 32'h00000000;
      st_reg.rresp <= `I2TM_RESP_OKAY;
      // idle bus is high; starting high avoids false edges after reset
      st_reg.scl_m <= 1'b1;
      st_reg.scl_s <= 1'b1;
      st_reg.scl_d <= 1'b1;
      st_reg.sda_m <= 1'b1;
      st_reg.sda_s <= 1'b1;
      st_reg.sda_d <= 1'b1;
      st_reg.sub_m <= 1'b0;
      st_reg.sub_s <= 1'b0;
      st_reg.sub_d <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign engine_reset = st_reg.eng_rst;
  assign serial_control_second = st_reg.sc2;
  // one interrupt line shared by match and time-out events
  assign irq = |(st_reg.ist & st_reg.ien);

  // period span is fixed by the sub clock rate: 1..64 x 32 sub cycles
  // with a 32768 hz sub clock that is about 1 ms to 64 ms
  logic unused_ok;
  assign unused_ok = timeout_flag;

endmodule : i2tm_supervisor

// >>> verif/i2tm_mst_model.sv
// i2c bus master stand-in: drives scl, sda and the slave engine's own-address pulse
module i2tm_mst_model (
  input wire logic aclk, // system clock
  output logic scl, // serial clock line
  output logic sda, // serial data line
  output logic addr_match // own address seen, one cycle
);
  timeunit 1ns;
  timeprecision 1ns;

  // lines rest high on their pull-ups, so reset sees no false edges
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    addr_match = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  // sda falls while scl is high, then scl is pulled low
  task automatic start();
    sda <= 1'b0;
    idle(10);
    scl <= 1'b0;
    idle(10);
  endtask : start

  // sda rises while scl is high; both lines left released
  task automatic stop();
    sda <= 1'b0;
    idle(10);
    scl <= 1'b1;
    idle(10);
    sda <= 1'b1;
    idle(10);
  endtask : stop

  // one bit: data flips every bit so a stale level never looks valid; falls 5 cycles before return
  task automatic pulse();
    sda <= ~sda;
    idle(5);
    scl <= 1'b1;
    idle(10);
    scl <= 1'b0;
    idle(5);
  endtask : pulse

  // stand-in for the slave engine's compare result
  task automatic match();
    addr_match <= 1'b1;
    idle(1);
    addr_match <= 1'b0;
    idle(1);
  endtask : match

  // address byte plus acknowledge, then scl held low by the stalled master
  task automatic addr();
    repeat (9) pulse();
    sda <= 1'b1;
    match();
  endtask : addr
endmodule : i2tm_mst_model

// >>> verif/i2tm_sup_properties.sv
// assertion checker for the i2c time-out supervisor, bound to its top module
`include "i2tm_params.svh"

module i2tm_sup_properties (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bready, // write response ready
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read data valid
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rready, // read data ready
  input wire logic scl_in, // scl pin level
  input wire logic sda_in, // sda pin level
  input wire logic sub_clock, // sub clock pin
  input wire logic addr_match, // own address pulse
  input wire logic engine_reset, // time-out reset pulse
  input wire logic [7:0] serial_control_second // second control register
);
  timeunit 1ns;
  timeprecision 1ns;

  // --------
  // helper state
  // --------
  logic scl_q, sda_q, sub_q, matched;
  logic [15:0] sub_since;

  // raw pin view runs ahead of the design's synchronisers, so counts here are never short
  always_ff @(posedge aclk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    sub_q <= sub_clock;
    if (!aresetn) begin
      matched <= 1'b0;
      sub_since <= 16'h0000;
    end else begin
      if (addr_match) matched <= 1'b1;
      else if (engine_reset || (scl_in && scl_q && sda_in != sda_q)) matched <= 1'b0;
      if (scl_q && !scl_in) sub_since <= 16'h0000;
      else if (sub_clock && !sub_q && sub_since != 16'hFFFF) sub_since <= sub_since + 16'h0001;
    end
  end

  // --------
  // properties
  // --------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_one_cycle: assert property (engine_reset |=> !engine_reset)
    else $error("engine reset longer than one cycle");
  chk_sc2_cleared: assert property (engine_reset |-> ##[0:1] serial_control_second == 8'h00)
    else $error("second control register not cleared on time-out");
  chk_match_first: assert property (engine_reset |-> matched)
    else $error("time-out without a live address match");
  chk_fall_restarts: assert property (engine_reset |-> sub_since >= 16'h001F)
    else $error("time-out too soon after an scl fall");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule : i2tm_sup_properties

bind i2tm_supervisor i2tm_sup_properties chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rready(s_axi_rready), .scl_in(scl_in), .sda_in(sda_in),
  .sub_clock(sub_clock), .addr_match(addr_match), .engine_reset(engine_reset),
  .serial_control_second(serial_control_second));

// >>> verif/tb_top.sv
// self-checking bench for the i2c time-out supervisor
`include "i2tm_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic aclk = 1'b0, aresetn = 1'b0, sub_clock = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, sc2;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, eng_rst, irq, scl, sda, am;
  logic [1:0] bresp, rresp;
  int failures = 0, samples_checked = 0, cyc = 0, rst_cnt = 0;

  i2tm_supervisor dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_in(scl),
    .sda_in(sda), .sub_clock(sub_clock), .addr_match(am), .engine_reset(eng_rst),
    .serial_control_second(sc2), .irq(irq));

  i2tm_mst_model mst (.aclk(aclk), .scl(scl), .sda(sda), .addr_match(am));

  // --------
  // clocks, event count and hang guard
  // --------
  always #50 aclk = ~aclk;
  // sub clock at 800 ns, offset so its edges never coincide with aclk edges
  initial begin
    #137;
    forever #400 sub_clock = ~sub_clock;
  end
  always @(posedge aclk) begin
    cyc++;
    if (eng_rst === 1'b1) rst_cnt++;
    if (cyc > 40000) begin
      failures++;
      test_done();
    end
  end

  // --------
  // shared tasks
  // --------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // bready is raised one cycle late so the response must stand while unanswered
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `I2TM_RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(bresp, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = `I2TM_RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, exp);
    check(rresp, er);
  endtask : rd

  // waits for one time-out pulse and judges its distance from t0
  task automatic wait_rst(input int t0, input int lo, input int hi);
    int c0;
    c0 = rst_cnt;
    for (int i = 0; i < hi + 50 && rst_cnt == c0; i++) @(posedge aclk);
    check(rst_cnt, c0 + 1);
    check((cyc - t0 >= lo) && (cyc - t0 <= hi), 1'b1);
  endtask : wait_rst

  task automatic quiet(input int n);
    int c0;
    c0 = rst_cnt;
    repeat (n) @(posedge aclk);
    check(rst_cnt, c0);
  endtask : quiet

  // --------
  // scenarios
  // --------
  // reset values, read-only and unmapped places, flag not settable by software
  task automatic t_regs();
    rd(`I2TM_ADDR_CTRL, 32'h0);
    rd(`I2TM_ADDR_INT_STAT, 32'h0);
    rd(`I2TM_ADDR_INT_EN, 32'h0);
    rd(`I2TM_ADDR_SC2, 32'h0);
    rd(8'h14, 32'h0, `I2TM_RESP_SLVERR);
    wr(8'h14, 32'h1, `I2TM_RESP_SLVERR);
    wr(`I2TM_ADDR_INT_STAT, 32'hFF);
    rd(`I2TM_ADDR_INT_STAT, 32'h0);
    rd(`I2TM_ADDR_INT_CLR, 32'h0);
    wr(`I2TM_ADDR_CTRL, 32'h7F);
    rd(`I2TM_ADDR_CTRL, 32'h3F);
    wr(`I2TM_ADDR_CTRL, 32'h0);
  endtask : t_regs

  // shortest period after start and match; effects of the time-out
  task automatic t_basic();
    int t0;
    wr(`I2TM_ADDR_INT_EN, 32'h1);
    wr(`I2TM_ADDR_CTRL, 32'h80);
    wr(`I2TM_ADDR_SC2, 32'hA5);
    mst.start();
    mst.addr();
    t0 = cyc;
    rd(`I2TM_ADDR_SC2, 32'hA5);
    check(sc2, 32'hA5);
    rd(`I2TM_ADDR_INT_STAT, 32'h2);
    wait_rst(t0, 248, 290);
    rd(`I2TM_ADDR_CTRL, 32'h40);
    rd(`I2TM_ADDR_SC2, 32'h00);
    check(sc2, 32'h0);
    rd(`I2TM_ADDR_INT_STAT, 32'h3);
    check(irq, 1'b1);
    wr(`I2TM_ADDR_INT_CLR, 32'h3);
    rd(`I2TM_ADDR_INT_STAT, 32'h0);
    check(irq, 1'b0);
    rd(`I2TM_ADDR_CTRL, 32'h40);
    wr(`I2TM_ADDR_CTRL, 32'h0);
    rd(`I2TM_ADDR_CTRL, 32'h0);
    mst.stop();
  endtask : t_basic

  // falls closer than (2+1)*32 sub edges keep it alive; then it expires on time
  task automatic t_alive();
    int c0;
    wr(`I2TM_ADDR_CTRL, 32'h82);
    mst.start();
    mst.addr();
    c0 = rst_cnt;
    repeat (4) begin
      mst.idle(600);
      mst.pulse();
    end
    check(rst_cnt, c0);
    wait_rst(cyc - 5, 760, 800);
    wr(`I2TM_ADDR_INT_CLR, 32'h3);
    wr(`I2TM_ADDR_CTRL, 32'h0);
    mst.stop();
  endtask : t_alive

  // stop ends supervision; a match outside a frame is not honoured
  task automatic t_stop();
    wr(`I2TM_ADDR_CTRL, 32'h80);
    mst.start();
    mst.addr();
    mst.stop();
    quiet(400);
    mst.match();
    quiet(400);
    rd(`I2TM_ADDR_CTRL, 32'h80);
    wr(`I2TM_ADDR_INT_CLR, 32'h3);
  endtask : t_stop

  // disabled counter holds at zero and starts fresh; masked interrupt stays low
  task automatic t_enable();
    wr(`I2TM_ADDR_INT_EN, 32'h0);
    wr(`I2TM_ADDR_CTRL, 32'h00);
    mst.start();
    mst.addr();
    quiet(400);
    wr(`I2TM_ADDR_CTRL, 32'h80);
    wait_rst(cyc, 240, 290);
    rd(`I2TM_ADDR_INT_STAT, 32'h3);
    check(irq, 1'b0);
    wr(`I2TM_ADDR_INT_EN, 32'h1);
    rd(`I2TM_ADDR_INT_EN, 32'h1);
    check(irq, 1'b1);
    wr(`I2TM_ADDR_INT_CLR, 32'h3);
    mst.stop();
  endtask : t_enable

  // --------
  // main sequence
  // --------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_basic();
    t_alive();
    t_stop();
    t_enable();
    test_done();
  end
endmodule : tb_top
